// ==== common/temp_board_pkg.sv ====
// Function
// - Seven byte registers at switch-selected base
// - Offset 6 write loads pulse counter
// - Pulse count valid after window elapsed
// - Window end raises interrupt when enabled
// - Window and scan reads return count
// - Scan rate is prescaler over count
// - Control bits 7:6 select counter
// - Control bits 5:4 select access kind
// - Mode 0 counts down while gate high
// - Mode 1 one-shot lasts count board clocks
// - Control bit 0 selects binary or BCD
// - Offset 3 read triggers a conversion
// - Offset 4 write sets channel and enable
// - Channel and enable clear at reset
// - Offset 4 read returns channel number
// - Status bit 5 shows conversion busy
// - Status bit 6 shows calibrate switch
// - Status bit 7 flag; line only if enabled
// - Offset 5 read clears interrupt flag
// - Pulse counter gated by window output
// - Window counter clocked at 2 MHz
// - Pulse counter data writes only hold
package temp_board_pkg;

	localparam int           SYS_CLK_HZ   = 10_000_000;
	localparam int           BOARD_CLK_HZ = 2_000_000;
	localparam int           BOARD_DIV    = SYS_CLK_HZ / BOARD_CLK_HZ;
	localparam logic [2:0]   BOARD_DIV_LAST = 3'(BOARD_DIV - 1);

	localparam int           ADDR_W      = 10;
	localparam logic         BASE_TOP    = 1'b1;
	localparam logic [2:0]   OFS_PULSE   = 3'h0;
	localparam logic [2:0]   OFS_WINDOW  = 3'h1;
	localparam logic [2:0]   OFS_SCAN    = 3'h2;
	localparam logic [2:0]   OFS_CTRL    = 3'h3;
	localparam logic [2:0]   OFS_CHAN    = 3'h4;
	localparam logic [2:0]   OFS_IRQ     = 3'h5;
	localparam logic [2:0]   OFS_LOAD    = 3'h6;

	localparam int           CW_SEL_LO   = 6;
	localparam int           CW_ACC_LO   = 4;
	localparam int           CW_MODE_LO  = 1;
	localparam int           CW_BCD      = 0;
	localparam logic [1:0]   SEL_READBACK = 2'h3;

	typedef enum logic [1:0] {
		ACC_LATCH = 2'h0,
		ACC_LO    = 2'h1,
		ACC_HI    = 2'h2,
		ACC_BOTH  = 2'h3
	} access_e;

	localparam logic [2:0]   MODE_EVENT   = 3'h0;
	localparam logic [2:0]   MODE_ONESHOT = 3'h1;
	localparam logic [2:0]   MODE_RATE    = 3'h2;

	localparam int           CHAN_W      = 5;
	localparam int           CHAN_EN_BIT = 7;
	localparam int           IRQ_TMRE    = 3;
	localparam int           IRQ_PRE_LO  = 4;
	localparam logic [2:0]   ISEL_MIN    = 3'h2;
	localparam logic [3:0]   PRESC_MIN   = 4'h2;
	localparam logic [15:0]  COUNT_ONE   = 16'h0001;

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] init;
		logic [15:0] latch;
		logic        latched;
		logic [2:0]  mode;
		access_e     acc;
		logic        bcd;
		logic        wr_hi;
		logic        rd_hi;
		logic        armed;
		logic        out;
	} counter_s;

	typedef struct packed {
		logic [2:0]        rd_n_sync;
		logic [2:0]        wr_n_sync;
		logic [2:0]        vf_sync;
		logic [1:0]        cal_sync;
		logic [1:0][9:0]   addr_sync;
		logic [1:0][7:0]   data_sync;
		logic [1:0][5:0]   base_sync;
		counter_s [2:0]    ctr;
		logic [CHAN_W-1:0] chan;
		logic              mux_en;
		logic [7:0]        irq_ctl;
		logic              irq_flag;
		logic [2:0]        div_cnt;
		logic [15:0]       presc_cnt;
		logic [7:0]        dout;
		logic              doe;
		logic [7:0]        line_oe;
		logic              line_lvl;
	} board_s;

	localparam board_s BOARD_RST = '0;

endpackage

// ==== core/temp_board_regs.sv ====
`timescale 1ns/1ns
module temp_board_regs
	import temp_board_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] io_addr,
	input  wire logic [7:0]        io_data_in,
	output logic      [7:0]        io_data_out,
	output logic                   io_data_oe,
	input  wire logic              io_rd_n,
	input  wire logic              io_wr_n,
	input  wire logic [5:0]        base_switch,
	input  wire logic              vf_pulse,
	input  wire logic              cal_switch,
	output logic                   mux_connect_enable,
	output logic      [CHAN_W-1:0] channel_number,
	output logic                   irq_level,
	output logic      [7:0]        irq_line_oe
);

	board_s r_reg;
	board_s r_next;

	function automatic logic [15:0] cnt_dec(input logic [15:0] v,
		input logic bcd);
		logic [15:0] res;
		logic        brw;
		res = v;
		brw = 1'b1;
		if (!bcd)
		begin
			res = v - 16'h0001;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (brw)
				begin
					if (res[4*i +: 4] == 4'h0)
					begin
						res[4*i +: 4] = 4'h9;
					end
					else
					begin
						res[4*i +: 4] = res[4*i +: 4] - 4'h1;
						brw = 1'b0;
					end
				end
			end
		end
		return res;
	endfunction

	// One counting step per counter
	function automatic counter_s cnt_step(input counter_s c,
		input logic ev, input logic gate, input logic trig);
		counter_s n;
		n = c;
		case (c.mode)
			MODE_EVENT:
			begin
				if (c.armed && gate && ev)
				begin
					n.count = cnt_dec(c.count, c.bcd);
					if (c.count == COUNT_ONE)
						n.out = 1'b1;
				end
			end
			MODE_ONESHOT:
			begin
				if (c.armed && trig)
				begin
					n.count = c.init;
					n.out   = 1'b1;
				end
				else if (c.out && ev)
				begin
					n.count = cnt_dec(c.count, c.bcd);
					if (c.count == COUNT_ONE)
						n.out = 1'b0;
				end
			end
			MODE_RATE:
			begin
				if (c.armed && gate && ev)
				begin
					if (c.count == COUNT_ONE)
						n.count = c.init;
					else
						n.count = cnt_dec(c.count, c.bcd);
				end
			end
			default:
			begin
				n = c;
			end
		endcase
		return n;
	endfunction

	function automatic counter_s cnt_write(input counter_s c,
		input logic [7:0] d, input logic may_load);
		counter_s n;
		logic     done;
		n = c;
		done = 1'b0;
		case (c.acc)
			ACC_LO:
			begin
				n.init[7:0] = d;
				done = 1'b1;
			end
			ACC_HI:
			begin
				n.init[15:8] = d;
				done = 1'b1;
			end
			ACC_BOTH:
			begin
				if (!c.wr_hi)
					n.init[7:0] = d;
				else
					n.init[15:8] = d;
				n.wr_hi = !c.wr_hi;
				done = c.wr_hi;
			end
			default:
			begin
				done = 1'b0;
			end
		endcase
		if (done && may_load)
		begin
			n.armed = 1'b1;
			if (c.mode != MODE_ONESHOT)
			begin
				n.count = n.init;
				n.out   = 1'b0;
			end
		end
		return n;
	endfunction

	function automatic counter_s cnt_read(input counter_s c,
		output logic [7:0] d);
		counter_s    n;
		logic [15:0] src;
		logic        hi;
		n = c;
		src = c.latched ? c.latch : c.count;
		hi = (c.acc == ACC_HI) || (c.acc == ACC_BOTH && c.rd_hi);
		d = hi ? src[15:8] : src[7:0];
		if (c.acc == ACC_BOTH)
			n.rd_hi = !c.rd_hi;
		if (c.acc != ACC_BOTH || c.rd_hi)
			n.latched = 1'b0;
		return n;
	endfunction

	always_comb
	begin
		logic              rd_edge;
		logic              wr_edge;
		logic              hit;
		logic [2:0]        ofs;
		logic [7:0]        wd;
		logic [7:0]        rd;
		logic [1:0]        sel;
		logic              board_tick;
		logic              presc_tick;
		logic              tmre;
		logic              scan_term;
		logic              trig;
		logic [3:0]        pre;
		logic [15:0]       mask;
		rd = 8'h00;
		sel = 2'h0;
		r_next = r_reg;
		r_next.rd_n_sync = {r_reg.rd_n_sync[1:0], io_rd_n};
		r_next.wr_n_sync = {r_reg.wr_n_sync[1:0], io_wr_n};
		r_next.vf_sync   = {r_reg.vf_sync[1:0], vf_pulse};
		r_next.cal_sync  = {r_reg.cal_sync[0], cal_switch};
		r_next.addr_sync = {r_reg.addr_sync[0], io_addr};
		r_next.data_sync = {r_reg.data_sync[0], io_data_in};
		r_next.base_sync = {r_reg.base_sync[0], base_switch};

		rd_edge = !r_reg.rd_n_sync[1] && r_reg.rd_n_sync[2];
		wr_edge = !r_reg.wr_n_sync[1] && r_reg.wr_n_sync[2];
		ofs = r_reg.addr_sync[1][2:0];
		wd  = r_reg.data_sync[1];
		hit = (r_reg.addr_sync[1][9] == BASE_TOP)
			&& (r_reg.addr_sync[1][8:3] == r_reg.base_sync[1])
			&& (ofs <= OFS_LOAD);

		// 2 MHz board clock from the system clock
		board_tick = (r_reg.div_cnt == BOARD_DIV_LAST);
		r_next.div_cnt = board_tick ? 3'h0 : r_reg.div_cnt + 3'h1;

		tmre = r_reg.irq_ctl[IRQ_TMRE];
		pre  = r_reg.irq_ctl[IRQ_PRE_LO +: 4];
		mask = 16'((17'h00001 << pre) - 17'h00001);
		presc_tick = board_tick && tmre && (pre >= PRESC_MIN)
			&& ((r_reg.presc_cnt & mask) == mask);
		if (!tmre)
			r_next.presc_cnt = 16'h0000;
		else if (board_tick)
			r_next.presc_cnt = r_reg.presc_cnt + 16'h0001;

		scan_term = presc_tick && tmre && r_reg.ctr[2].armed
			&& (r_reg.ctr[2].mode == MODE_RATE)
			&& (r_reg.ctr[2].count == COUNT_ONE);
		trig = (hit && rd_edge && ofs == OFS_CTRL) || scan_term;

		r_next.ctr[0] = cnt_step(r_reg.ctr[0],
			r_reg.vf_sync[1] && !r_reg.vf_sync[2], r_reg.ctr[1].out,
			1'b0);
		r_next.ctr[1] = cnt_step(r_reg.ctr[1], board_tick, 1'b1, trig);
		r_next.ctr[2] = cnt_step(r_reg.ctr[2], presc_tick, tmre, 1'b0);

		// Window end: sticky flag, set wins over a clearing read
		if (hit && rd_edge && ofs == OFS_IRQ)
			r_next.irq_flag = 1'b0;
		if (r_reg.ctr[1].out && !r_next.ctr[1].out)
			r_next.irq_flag = 1'b1;

		if (hit && wr_edge)
		begin
			if (ofs <= OFS_SCAN)
			begin
				r_next.ctr[ofs[1:0]] = cnt_write(r_next.ctr[ofs[1:0]], wd,
					ofs != OFS_PULSE);
			end
			else if (ofs == OFS_CTRL)
			begin
				sel = wd[CW_SEL_LO +: 2];
				if (sel != SEL_READBACK)
				begin
					if (access_e'(wd[CW_ACC_LO +: 2]) == ACC_LATCH)
					begin
						if (!r_next.ctr[sel].latched)
						begin
							r_next.ctr[sel].latch = r_next.ctr[sel].count;
							r_next.ctr[sel].latched = 1'b1;
						end
					end
					else
					begin
						r_next.ctr[sel].acc = access_e'(wd[CW_ACC_LO +: 2]);
						r_next.ctr[sel].mode = wd[CW_MODE_LO +: 3];
						r_next.ctr[sel].bcd = wd[CW_BCD];
						r_next.ctr[sel].wr_hi = 1'b0;
						r_next.ctr[sel].rd_hi = 1'b0;
						r_next.ctr[sel].armed = 1'b0;
						r_next.ctr[sel].out = 1'b0;
						r_next.ctr[sel].latched = 1'b0;
					end
				end
			end
			else if (ofs == OFS_CHAN)
			begin
				r_next.chan = wd[CHAN_W-1:0];
				r_next.mux_en = wd[CHAN_EN_BIT];
			end
			else if (ofs == OFS_IRQ)
			begin
				r_next.irq_ctl = wd;
			end
			else
			begin
				r_next.ctr[0].count = r_next.ctr[0].init;
				r_next.ctr[0].armed = 1'b1;
				r_next.ctr[0].out = 1'b0;
			end
		end

		if (hit && rd_edge)
		begin
			if (ofs <= OFS_SCAN)
			begin
				r_next.ctr[ofs[1:0]] = cnt_read(r_next.ctr[ofs[1:0]], rd);
			end
			else if (ofs == OFS_CHAN)
			begin
				rd = {r_reg.irq_flag, r_reg.cal_sync[1],
					r_reg.ctr[1].out, r_reg.chan};
			end
			else if (ofs == OFS_IRQ)
			begin
				rd = r_reg.irq_ctl;
			end
			else
			begin
				rd = 8'h00;
			end
			r_next.dout = rd;
		end
		r_next.doe = hit && !r_reg.rd_n_sync[1];

		// Request line driven only for a valid selection
		r_next.line_lvl = r_next.irq_flag;
		r_next.line_oe = 8'h00;
		if (r_reg.irq_ctl[2:0] >= ISEL_MIN)
			r_next.line_oe[r_reg.irq_ctl[2:0]] = 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			r_reg <= BOARD_RST;
		else
			r_reg <= r_next;
	end

	assign io_data_out        = r_reg.dout;
	assign io_data_oe         = r_reg.doe;
	assign mux_connect_enable = r_reg.mux_en;
	assign channel_number     = r_reg.chan;
	assign irq_level          = r_reg.line_lvl;
	assign irq_line_oe        = r_reg.line_oe;

endmodule

// ==== verif/temp_board_asserts.sv ====
`timescale 1ns/1ns
module temp_board_asserts
	import temp_board_pkg::*;
(
	input wire logic		sys_clk,
	input wire logic		rst_n,
	input wire logic [ADDR_W-1:0]	io_addr,
	input wire logic [7:0]		io_data_in,
	input wire logic [7:0]		io_data_out,
	input wire logic		io_data_oe,
	input wire logic		io_rd_n,
	input wire logic		io_wr_n,
	input wire logic [5:0]		base_switch,
	input wire logic		vf_pulse,
	input wire logic		cal_switch,
	input wire logic		mux_connect_enable,
	input wire logic [CHAN_W-1:0]	channel_number,
	input wire logic		irq_level,
	input wire logic [7:0]		irq_line_oe
);
	logic	[3:0]	rd_age;
	logic		hit;
	assign hit = io_addr[9] && io_addr[8:3] == base_switch
		&& io_addr[2:0] != 3'h7;
	// Cycles since the read strobe was last low
	always_ff @(posedge sys_clk)
		rd_age <= !rst_n ? 4'hf
			: io_rd_n ? rd_age + 4'(rd_age != 4'hf) : 4'h0;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence hit_rd;
		$fell(io_rd_n) && hit;
	endsequence
	sequence rd_of(logic [2:0] o);
		$rose(io_data_oe) && io_addr[2:0] == o;
	endsequence
	rst_clear_a: assert property (disable iff (1'b0) !rst_n |=>
		channel_number == '0 && !mux_connect_enable && !irq_level)
		else $error("outputs not cleared by reset");
	oe_hit_a: assert property (hit_rd |-> ##[1:4] io_data_oe)
		else $error("read of own register not answered");
	oe_miss_a: assert property ((io_rd_n || !hit) [*5] |-> !io_data_oe)
		else $error("data driven without own read");
	chan_hold_a: assert property (io_wr_n [*5] |=>
		$stable(channel_number) && $stable(mux_connect_enable))
		else $error("channel changed without write");
	ch_read_a: assert property (rd_of(OFS_CHAN) |->
		io_data_out[4:0] == channel_number)
		else $error("channel readback wrong");
	cal_read_a: assert property (rd_of(OFS_CHAN) |->
		io_data_out[6] == cal_switch)
		else $error("calibrate bit wrong");
	int_read_a: assert property (rd_of(OFS_CHAN) |-> io_data_out[7] ==
		irq_level || io_data_out[7] == $past(irq_level))
		else $error("interrupt bit wrong");
	no_data_a: assert property ($rose(io_data_oe)
		&& (io_addr[2:0] == OFS_CTRL || io_addr[2:0] == OFS_LOAD)
		|-> io_data_out == 8'h00)
		else $error("trigger or load read returned data");
	line_hot_a: assert property ($onehot0(irq_line_oe)
		&& irq_line_oe[1:0] == 2'b00)
		else $error("bad request line enable");
	irq_clr_a: assert property ($fell(irq_level) |-> rd_age < 4'h8)
		else $error("interrupt flag cleared without read");
endmodule
bind temp_board_regs temp_board_asserts temp_board_asserts_i (
	.sys_clk(sys_clk), .rst_n(rst_n), .io_addr(io_addr),
	.io_data_in(io_data_in), .io_data_out(io_data_out),
	.io_data_oe(io_data_oe), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n),
	.base_switch(base_switch), .vf_pulse(vf_pulse),
	.cal_switch(cal_switch), .mux_connect_enable(mux_connect_enable),
	.channel_number(channel_number), .irq_level(irq_level),
	.irq_line_oe(irq_line_oe));

// ==== verif/host_bus_model.sv ====
`timescale 1ns/1ns
module host_bus_model
	import temp_board_pkg::*;
(
	input wire logic		sys_clk,
	input wire logic [5:0]		base,
	input wire logic [7:0]		io_data_out,
	input wire logic		io_data_oe,
	output logic [ADDR_W-1:0]	io_addr,
	output logic [7:0]		io_data_in,
	output logic			io_rd_n,
	output logic			io_wr_n
);
	initial
	begin
		io_addr = '0;
		io_data_in = '0;
		io_rd_n = 1'b1;
		io_wr_n = 1'b1;
	end
	task automatic acc(input logic rd, input logic [2:0] ofs,
		input logic [7:0] d, output logic [7:0] q, output logic ok);
		ok = 1'b0;
		q = '0;
		@(posedge sys_clk);
		io_addr <= {1'b1, base, ofs};
		io_data_in <= d;
		io_rd_n <= !rd;
		io_wr_n <= rd;
		repeat (6)
		begin
			@(posedge sys_clk);
			if (io_data_oe === 1'b1 && !ok)
			begin
				ok = 1'b1;
				q = io_data_out;
			end
		end
		io_rd_n <= 1'b1;
		io_wr_n <= 1'b1;
		// Released bus shows inverted junk, never a hit
		io_data_in <= ~d;
		io_addr <= ~io_addr;
		repeat (5) @(posedge sys_clk);
	endtask
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ns
module tb
	import temp_board_pkg::*;
;
	localparam logic [7:0] WIN = 8'h14;
	logic		sys_clk = 1'b0;
	logic		rst_n = 1'b0;
	logic		vf_pulse = 1'b0;
	logic		cal_switch = 1'b0;
	logic [5:0]	base_switch = 6'h15;
	logic [9:0]	io_addr;
	logic [7:0]	io_data_in, io_data_out, irq_line_oe, q;
	logic		io_data_oe, io_rd_n, io_wr_n, ok, irq_level, mux_en;
	logic [4:0]	channel_number;
	logic [15:0]	cnt;
	int		n_errors = 0;
	int		n_checks = 0;
	int		cyc = 0;
	int		i;
	temp_board_regs temp_board_regs_i (.sys_clk(sys_clk), .rst_n(rst_n),
		.io_addr(io_addr), .io_data_in(io_data_in),
		.io_data_out(io_data_out), .io_data_oe(io_data_oe),
		.io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .base_switch(base_switch),
		.vf_pulse(vf_pulse), .cal_switch(cal_switch),
		.mux_connect_enable(mux_en), .channel_number(channel_number),
		.irq_level(irq_level), .irq_line_oe(irq_line_oe));
	host_bus_model host_bus_model_i (.sys_clk(sys_clk), .base(base_switch),
		.io_data_out(io_data_out), .io_data_oe(io_data_oe),
		.io_addr(io_addr), .io_data_in(io_data_in),
		.io_rd_n(io_rd_n), .io_wr_n(io_wr_n));
	always #50 sys_clk = ~sys_clk;
	// Converter output at one eighth of the clock
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc % 4 == 0)
			vf_pulse <= ~vf_pulse;
		if (cyc == 5000)
		begin
			n_errors++;
			end_sim;
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic io(input logic r, input logic [2:0] o, input logic [7:0] d);
		host_bus_model_i.acc(r, o, d, q, ok);
	endtask
	task automatic rd16(input logic [2:0] o, input logic [7:0] lc);
		io(1'b0, OFS_CTRL, lc);
		io(1'b1, o, 8'h00);
		cnt[7:0] = q;
		io(1'b1, o, 8'h00);
		cnt[15:8] = q;
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk({channel_number, mux_en}, 16'h0);
		io(1'b0, OFS_CHAN, 8'he5);
		chk({mux_en, channel_number}, 16'h25);
		io(1'b1, OFS_CHAN, 8'h00);
		chk(q[4:0], 16'h5);
		cal_switch <= 1'b1;
		io(1'b1, OFS_CHAN, 8'h00);
		chk(q[6], 16'h1);
		io(1'b1, 3'h7, 8'h00);
		chk(ok, 16'h0);
		io(1'b1, OFS_LOAD, 8'h00);
		chk(q, 16'h0);
		$display("test select done");
		io(1'b0, OFS_CTRL, 8'h72);
		io(1'b0, OFS_WINDOW, WIN);
		io(1'b0, OFS_WINDOW, 8'h00);
		io(1'b0, OFS_CTRL, 8'h30);
		io(1'b0, OFS_PULSE, 8'hff);
		io(1'b0, OFS_PULSE, 8'hff);
		rd16(OFS_PULSE, 8'h00);
		chk(cnt, 16'h0);
		io(1'b0, OFS_LOAD, 8'h00);
		io(1'b1, OFS_CTRL, 8'h00);
		chk(q, 16'h0);
		io(1'b1, OFS_CHAN, 8'h00);
		chk(q[5], 16'h1);
		for (i = 0; i < 20 && q[5] !== 1'b0; i++)
			io(1'b1, OFS_CHAN, 8'h00);
		chk(q[7:5], 16'h6);
		chk(irq_level, 16'h1);
		chk(irq_line_oe, 16'h0);
		rd16(OFS_PULSE, 8'h00);
		cnt = 16'hffff - cnt;
		// Window of WIN board ticks sees WIN*5/8 converter edges
		chk(16'(cnt >= 16'(WIN) * 5 / 8 - 2), 16'h1);
		chk(16'(cnt <= 16'(WIN) * 5 / 8 + 2), 16'h1);
		rd16(OFS_WINDOW, 8'h40);
		chk(cnt, 16'h0);
		io(1'b1, OFS_IRQ, 8'h00);
		io(1'b1, OFS_CHAN, 8'h00);
		chk(q[7], 16'h0);
		io(1'b0, OFS_IRQ, 8'h03);
		chk(irq_line_oe, 16'h08);
		io(1'b1, OFS_IRQ, 8'h00);
		chk(q, 16'h03);
		$display("test conversion done");
		io(1'b0, OFS_CTRL, 8'hb4);
		io(1'b0, OFS_SCAN, 8'h00);
		io(1'b0, OFS_SCAN, 8'h04);
		rd16(OFS_SCAN, 8'h80);
		chk(cnt, 16'h0400);
		io(1'b0, OFS_CTRL, 8'ha4);
		io(1'b0, OFS_SCAN, 8'h12);
		io(1'b0, OFS_CTRL, 8'h80);
		io(1'b1, OFS_SCAN, 8'h00);
		chk(q, 16'h12);
		io(1'b0, OFS_CTRL, 8'h94);
		io(1'b0, OFS_SCAN, 8'h34);
		io(1'b0, OFS_CTRL, 8'h80);
		io(1'b1, OFS_SCAN, 8'h00);
		chk(q, 16'h34);
		$display("test scan done");
		// BCD scan of 16 ticks at 500 kHz, then a 20 tick window
		io(1'b0, OFS_CTRL, 8'hb5);
		io(1'b0, OFS_SCAN, 8'h16);
		io(1'b0, OFS_SCAN, 8'h00);
		io(1'b0, OFS_IRQ, 8'h2b);
		repeat (300) @(posedge sys_clk);
		chk(irq_level, 16'h0);
		repeat (150) @(posedge sys_clk);
		chk(irq_level, 16'h1);
		$display("test timer done");
		end_sim;
	end
endmodule
